// File: hw/srp_pkg.sv
// Purpose: shared constants and types for the bus management read path
// Assumes: one clock, bus pins sampled synchronously
// Notes:   shared offsets, counts and codes live here; the block byte positions 33 and 34 are fixed in the read path
package srp_pkg;
   localparam logic [6:0] SLAVE_ADDR     = 7'h2C;
   localparam logic [7:0] CMD_BLOCK_RD   = 8'hA1;
   localparam logic [7:0] CMD_BLOCK_WR   = 8'hA0;
   localparam logic [7:0] EE_HI_MIN      = 8'h80;
   localparam logic [7:0] EE_HI_MAX      = 8'h9F;
   localparam logic [7:0] RAM_TOP        = 8'h6F;
   localparam logic [7:0] BLOCK_COUNT    = 8'h20;
   localparam logic [7:0] CRC_POLY       = 8'h07;
   localparam logic [7:0] CRC_INIT       = 8'h00;
   localparam logic [7:0] EE_MODE_RST    = 8'h00;
   localparam int         EE_READ_BIT    = 0;
   localparam int         EE_PROG_BIT    = 1;
   localparam int         EE_ERASE_BIT   = 2;
   localparam logic [7:0] EE_MODE_ADDR   = 8'h13;
   localparam int         FIFO_DEPTH     = 16;
   localparam int         DATA_W         = 8;

   typedef enum logic [1:0] {
      SRP_SPACE_RAM,
      SRP_SPACE_EE
   } srp_space_type;

   // one crc-8 step per byte, msb first
   function automatic logic [7:0] srp_crc8(input logic [7:0] crc, input logic [7:0] data);
      logic [7:0] c;
      c = crc ^ data;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
      end
      return c;
   endfunction : srp_crc8

   function automatic logic srp_one_hot3(input logic [2:0] m);
      return (m == 3'b001) || (m == 3'b010) || (m == 3'b100);
   endfunction : srp_one_hot3
endpackage : srp_pkg

// File: hw/srp_stream_if.sv
// Purpose: valid/ready byte stream between read path and its fifo
// Assumes: single clock
// Notes:   src drives data and valid, snk drives ready
`timescale 1ns/1ps
`default_nettype none
interface srp_stream_if #(parameter int W = 8);
   logic [W-1:0] data;
   logic         valid;
   logic         ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface : srp_stream_if
`default_nettype wire

// File: hw/srp_fifo.sv
// Purpose: small synchronous fifo for outgoing read bytes
// Assumes: one clock, async active-low reset
// Notes:   full and empty are exact; ready tracks full
`timescale 1ns/1ps
`default_nettype none
module srp_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 16
) (
   input  wire logic ref_clk,
   input  wire logic nrst,
   input  wire logic flush,
   srp_stream_if.snk in_s,
   srp_stream_if.src out_s
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wr_q;
   logic [AW:0]  rd_q;
   wire          full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   wire          empty = (wr_q == rd_q);
   wire          push  = in_s.valid && !full;
   wire          pop   = out_s.ready && !empty;

   assign in_s.ready  = !full;
   assign out_s.valid = !empty;
   assign out_s.data  = mem[rd_q[AW-1:0]];

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wr_q[AW-1:0]] <= in_s.data;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         wr_q <= '0;
         rd_q <= '0;
      end else if (flush) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) wr_q <= wr_q + 1'b1;
         if (pop)  rd_q <= rd_q + 1'b1;
      end
   end
endmodule : srp_fifo
`default_nettype wire

// File: hw/srp_read_path.sv
// Purpose: slave side of a two-wire management bus, read path with pointer setup
// Assumes: scl/sda sampled on ref_clk (125 MHz, 8 ns); storage answers in the same cycle
// Notes:   block read streams count, 32 bytes and crc through a 16 word fifo
`timescale 1ns/1ps
`default_nettype none
module srp_read_path (
   input  wire logic                 ref_clk,
   input  wire logic                 nrst,
   input  wire logic                 scl_i,
   input  wire logic                 sda_i,
   output logic                      sda_o,
   output logic                      sda_oe,
   output logic [15:0]               mem_addr,
   output logic                      mem_sel_ee,
   input  wire logic [7:0]           mem_rdata,
   output logic                      wr_strobe,
   output logic [7:0]                wr_addr,
   output logic [7:0]                wr_data,
   output logic [7:0]                ee_mode
);
   import srp_pkg::*;

   // pec seed: address-write, block command and address-read never vary, so fold them in once
   localparam logic [7:0] BLK_CRC_SEED =
      srp_crc8(srp_crc8(srp_crc8(CRC_INIT, {SLAVE_ADDR, 1'b0}), CMD_BLOCK_RD), {SLAVE_ADDR, 1'b1});

   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_RX, ST_TX, ST_WAIT_ACK, ST_ACK} srp_state_type;

   ////////////////////////////////////////////////////////////////////////////
   logic          scl_q, sda_q, scl_p_q, sda_p_q;
   srp_state_type st_q;
   logic [7:0]    sh_q;
   logic [3:0]    bit_q;
   logic          rd_dir_q, ack_q, blk_arm_q, blk_q;
   logic [1:0]    wr_idx_q;
   logic [7:0]    cmd_q, crc_q;
   logic [15:0]   ram_ptr_q, ee_ptr_q;
   srp_space_type space_q;
   logic [5:0]    gen_cnt_q;
   logic [7:0]    ee_mode_q;
   logic          sda_o_q, sda_oe_q;

   wire scl_rise  = scl_q && !scl_p_q;
   wire scl_fall  = !scl_q && scl_p_q;
   wire start_det = scl_q && scl_p_q && sda_p_q && !sda_q;
   wire stop_det  = scl_q && scl_p_q && !sda_p_q && sda_q;
   wire [7:0] rx_byte = {sh_q[6:0], sda_q};
   wire ee_mode_ok   = srp_one_hot3(ee_mode_q[2:0]) && ee_mode_q[EE_READ_BIT];
   wire read_allowed = (space_q == SRP_SPACE_RAM) || ee_mode_ok;
   wire addr_hit     = (rx_byte[7:1] == SLAVE_ADDR) &&
                       (!rx_byte[0] || read_allowed);
   wire is_ee_cmd    = (cmd_q >= EE_HI_MIN) && (cmd_q <= EE_HI_MAX);
   wire [15:0] cur_ptr = (space_q == SRP_SPACE_EE) ? ee_ptr_q : ram_ptr_q;

   ////////////////////////////////////////////////////////////////////////////
   // byte source: count, 32 data bytes, crc; fifo decouples memory from bit timing
   srp_stream_if #(.W(DATA_W)) gen_s ();
   srp_stream_if #(.W(DATA_W)) tx_s ();
   logic [15:0] gen_ptr_q;
   logic [7:0]  gen_crc_q;
   logic        gen_on_q, fifo_flush, gen_start, tx_pop;
   wire         gen_last_data = (gen_cnt_q == 6'd33);
   wire         gen_done      = (gen_cnt_q == 6'd34);
   wire         gen_fire      = gen_on_q && gen_s.ready && !gen_done && !fifo_flush;

   assign gen_s.valid = gen_on_q && !gen_done;
   assign gen_s.data  = (gen_cnt_q == 6'd0) ? BLOCK_COUNT :
                        (gen_cnt_q == 6'd33) ? gen_crc_q : mem_rdata;

   srp_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .flush   (fifo_flush),
      .in_s    (gen_s),
      .out_s   (tx_s)
   );

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         gen_on_q  <= 1'b0;
         gen_cnt_q <= '0;
         gen_ptr_q <= '0;
         gen_crc_q <= CRC_INIT;
      end else if (fifo_flush) begin
         gen_on_q  <= 1'b0;
         gen_cnt_q <= '0;
      end else if (gen_start) begin
         gen_on_q  <= 1'b1;
         gen_cnt_q <= '0;
         gen_ptr_q <= cur_ptr;
         gen_crc_q <= BLK_CRC_SEED;
      end else if (gen_fire) begin
         gen_cnt_q <= gen_cnt_q + 6'd1;
         gen_crc_q <= srp_crc8(gen_crc_q, gen_s.data);
         if (gen_cnt_q != 6'd0) gen_ptr_q <= gen_ptr_q + 16'd1;
         if (gen_last_data) gen_on_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign tx_s.ready = tx_pop;

   always_comb begin
      gen_start  = 1'b0;
      fifo_flush = start_det || stop_det;
      tx_pop     = 1'b0;
      if (st_q == ST_ADDR && scl_rise && bit_q == 4'd7 && addr_hit && rx_byte[0] && blk_arm_q)
         gen_start = 1'b1;
      if (st_q == ST_TX && scl_fall && bit_q == 4'd0 && blk_q)
         tx_pop = 1'b1;
   end

   assign mem_addr   = gen_on_q ? gen_ptr_q : cur_ptr;
   assign mem_sel_ee = (space_q == SRP_SPACE_EE);

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         scl_q <= 1'b1; sda_q <= 1'b1; scl_p_q <= 1'b1; sda_p_q <= 1'b1;
      end else begin
         scl_q <= scl_i; sda_q <= sda_i; scl_p_q <= scl_q; sda_p_q <= sda_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // main bit engine; drives sda only low, releases otherwise
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= ST_IDLE; sh_q <= '0; bit_q <= '0; rd_dir_q <= 1'b0; ack_q <= 1'b0;
         blk_arm_q <= 1'b0; blk_q <= 1'b0; wr_idx_q <= '0; cmd_q <= '0; crc_q <= CRC_INIT;
         ram_ptr_q <= '0; ee_ptr_q <= '0; space_q <= SRP_SPACE_RAM; ee_mode_q <= EE_MODE_RST;
         sda_o_q <= 1'b1; sda_oe_q <= 1'b0; wr_strobe <= 1'b0; wr_addr <= '0; wr_data <= '0;
      end else begin
         wr_strobe <= 1'b0;
         if (start_det) begin
            st_q <= ST_ADDR; bit_q <= '0; sda_oe_q <= 1'b0; blk_q <= 1'b0;
            if (!blk_arm_q) wr_idx_q <= '0;
         end else if (stop_det) begin
            st_q <= ST_IDLE; sda_oe_q <= 1'b0; blk_arm_q <= 1'b0; blk_q <= 1'b0;
            // an armed block command is no pointer; keep the space the block read from
            if (wr_idx_q == 2'd1 && !blk_arm_q) ram_ptr_q <= {8'h00, cmd_q};
            if (wr_idx_q == 2'd1 && !blk_arm_q) space_q <= SRP_SPACE_RAM;
         end else begin
            unique case (st_q)
               ST_IDLE: ;
               ST_ADDR, ST_RX: if (scl_rise) begin
                  sh_q  <= rx_byte;
                  bit_q <= bit_q + 4'd1;
                  if (bit_q == 4'd7) begin
                     bit_q <= '0;
                     if (st_q == ST_ADDR) begin
                        ack_q    <= addr_hit;
                        rd_dir_q <= rx_byte[0];
                        blk_q    <= rx_byte[0] && blk_arm_q;
                        if (!addr_hit) st_q <= ST_IDLE;
                        else st_q <= ST_ACK;
                     end else begin
                        ack_q <= 1'b1;
                        unique case (wr_idx_q)
                           2'd0: begin
                              cmd_q     <= rx_byte;
                              blk_arm_q <= (rx_byte == CMD_BLOCK_RD);
                              ack_q     <= (rx_byte != CMD_BLOCK_RD) || read_allowed;
                           end
                           2'd1: begin
                              if (is_ee_cmd) begin
                                 ee_ptr_q <= {cmd_q, rx_byte};
                                 space_q  <= SRP_SPACE_EE;
                              end else if (cmd_q == EE_MODE_ADDR) begin
                                 ee_mode_q <= rx_byte;
                              end else if (cmd_q <= RAM_TOP) begin
                                 wr_strobe <= 1'b1; wr_addr <= cmd_q; wr_data <= rx_byte;
                              end
                           end
                           default: ;
                        endcase
                        if (wr_idx_q != 2'd3) wr_idx_q <= wr_idx_q + 2'd1;
                        st_q <= ST_ACK;
                     end
                  end
               end
               ST_ACK: if (scl_fall) begin
                  // ack low during the ninth clock, then hand the line back or start sending
                  // own ack ends, or master acked a block byte: load the next one
                  if (sda_oe_q || (rd_dir_q && !ack_q)) begin
                     sda_oe_q <= 1'b0;
                     if (rd_dir_q) begin
                        st_q  <= ST_TX; bit_q <= '0;
                        sh_q  <= blk_q ? tx_s.data : mem_rdata;
                        sda_oe_q <= !(blk_q ? tx_s.data[7] : mem_rdata[7]);
                     end else st_q <= ST_RX;
                  end else if (ack_q) begin
                     sda_oe_q <= 1'b1; sda_o_q <= 1'b0;
                  end
               end
               ST_TX: if (scl_fall) begin
                  bit_q <= bit_q + 4'd1;
                  sh_q  <= {sh_q[6:0], 1'b0};
                  sda_oe_q <= !sh_q[6];
                  if (bit_q == 4'd7) begin
                     sda_oe_q <= 1'b0; st_q <= ST_WAIT_ACK; bit_q <= '0;
                  end
               end
               ST_WAIT_ACK: if (scl_rise) begin
                  st_q <= sda_q ? ST_IDLE : ST_ACK;
                  ack_q <= 1'b0;
                  if (!sda_q && !blk_q) st_q <= ST_IDLE;
               end
               default: st_q <= ST_IDLE;
            endcase
         end
      end
   end

   assign sda_o  = sda_o_q;
   assign sda_oe = sda_oe_q;
   assign ee_mode = ee_mode_q;

   ////////////////////////////////////////////////////////////////////////////
   sequence s_blk_addr;
      st_q == ST_ADDR && scl_rise && bit_q == 4'd7 && addr_hit && rx_byte[0] && blk_arm_q;
   endsequence
   AST_BLK_GEN_START: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_blk_addr |-> ##1 (gen_on_q && gen_cnt_q == 6'd0)) else $error("block generator not started");
   AST_EE_REFUSE: assert property (@(posedge ref_clk) disable iff (!nrst)
      (st_q == ST_ADDR && scl_rise && bit_q == 4'd7 && rx_byte[0] && space_q == SRP_SPACE_EE
       && !ee_mode_ok) |-> ##1 (st_q == ST_IDLE)) else $error("eeprom read not refused");
   AST_COUNT_FIRST: assert property (@(posedge ref_clk) disable iff (!nrst)
      (gen_fire && gen_cnt_q == 6'd0) |-> gen_s.data == BLOCK_COUNT) else $error("count byte wrong");
   AST_PTR_STEP: assert property (@(posedge ref_clk) disable iff (!nrst)
      (gen_fire && gen_cnt_q inside {[6'd1:6'd32]}) |=> gen_ptr_q == $past(gen_ptr_q) + 16'd1)
      else $error("pointer did not advance");
   AST_CRC_LAST: assert property (@(posedge ref_clk) disable iff (!nrst)
      (gen_fire && gen_cnt_q == 6'd33) |-> gen_s.data == gen_crc_q ##1 !gen_on_q)
      else $error("crc byte misplaced");
   AST_RAM_PTR_LOAD: assert property (@(posedge ref_clk) disable iff (!nrst)
      (stop_det && wr_idx_q == 2'd1 && !blk_arm_q)
         |=> (ram_ptr_q == {8'h00, $past(cmd_q)} && space_q == SRP_SPACE_RAM))
      else $error("ram pointer not loaded by send byte");
   AST_STOP_RELEASE: assert property (@(posedge ref_clk) disable iff (!nrst)
      stop_det |=> !sda_oe_q) else $error("data line still pulled after stop");
endmodule : srp_read_path
`default_nettype wire

// File: verification/srp_host_bfm.sv
// Purpose: bus master model for the read path, bit-banged scl and open-drain sda
// Assumes: one scl quarter period is Q ref_clk cycles; sda_line is the resolved wire
// Notes:   sda_drv high means released; the pull-up makes the wire high then
`timescale 1ns/1ps
`default_nettype none
module srp_host_bfm #(
   parameter int Q = 5
) (
   input  wire logic ref_clk,
   input  wire logic sda_line,
   output var logic  scl,
   output var logic  sda_drv
);
   initial begin
      scl     = 1'b1;
      sda_drv = 1'b1;
   end

   // every change lands just after a clock edge, never on it
   task automatic q;
      repeat (Q) @(posedge ref_clk);
      #1;
   endtask : q

   // also serves as repeated start, since scl is low between bytes
   task automatic start;
      sda_drv = 1'b1;
      q;
      scl = 1'b1;
      q;
      sda_drv = 1'b0;
      q;
      scl = 1'b0;
      q;
   endtask : start

   task automatic stop;
      sda_drv = 1'b0;
      q;
      scl = 1'b1;
      q;
      sda_drv = 1'b1;
      q;
   endtask : stop

   task automatic bit_io(input logic b, output logic r);
      sda_drv = b;
      q;
      scl = 1'b1;
      q;
      r = sda_line;
      q;
      scl = 1'b0;
      q;
   endtask : bit_io

   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, r);
      ack = ~r;
   endtask : wbyte

   // ack chosen by the caller: data and count acked, last byte not
   task automatic rbyte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(~ack, r);
   endtask : rbyte
endmodule : srp_host_bfm
`default_nettype wire

// File: verification/tb_top.sv
// Purpose: self-checking bench for the read path, receive byte and block read
// Assumes: storage answers combinationally from mem_addr and mem_sel_ee
// Notes:   storage content is a fixed pattern of the address, so every byte is predictable
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import srp_pkg::*;
   logic        ref_clk = 1'b0;
   logic        nrst    = 1'b0;
   logic        scl, sda_drv, sda_o, sda_oe, mem_sel_ee, sda_line;
   logic [15:0] mem_addr;
   logic [7:0]  mem_rdata, ee_mode;
   logic        wr_strobe;
   logic [7:0]  wr_addr, wr_data;
   logic [15:0] wr_cap = 16'h0000;
   int          wr_cnt = 0;
   int          num_errors = 0;
   int          cmp_count  = 0;

   always #4 ref_clk = ~ref_clk;

   function automatic logic [7:0] pat(input logic [15:0] a, input logic ee);
      return a[15:8] ^ a[7:0] ^ {ee, 7'h33};
   endfunction : pat

   assign mem_rdata = pat(mem_addr, mem_sel_ee);
   // open drain with pull-up: low if either party pulls
   assign sda_line  = sda_drv & (sda_oe ? sda_o : 1'b1);

   // ram data writes show only as a one-cycle strobe; keep the last one
   always @(posedge ref_clk) begin
      if (wr_strobe === 1'b1) begin
         wr_cap <= {wr_addr, wr_data};
         wr_cnt <= wr_cnt + 1;
      end
   end

   srp_read_path DUT (
      .ref_clk    (ref_clk),
      .nrst       (nrst),
      .scl_i      (scl),
      .sda_i      (sda_line),
      .sda_o      (sda_o),
      .sda_oe     (sda_oe),
      .mem_addr   (mem_addr),
      .mem_sel_ee (mem_sel_ee),
      .mem_rdata  (mem_rdata),
      .wr_strobe  (wr_strobe),
      .wr_addr    (wr_addr),
      .wr_data    (wr_data),
      .ee_mode    (ee_mode)
   );

   srp_host_bfm #(.Q(5)) HB (
      .ref_clk  (ref_clk),
      .sda_line (sda_line),
      .scl      (scl),
      .sda_drv  (sda_drv)
   );

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // independent crc-8, msb first, no reflection
   function automatic logic [7:0] tb_crc(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] x;
      x = c ^ d;
      repeat (8) x = {x[6:0], 1'b0} ^ (x[7] ? CRC_POLY : 8'h00);
      return x;
   endfunction : tb_crc

   task automatic send(input logic [7:0] b, input logic exp_ack);
      logic a;
      HB.wbyte(b, a);
      chk(a, exp_ack);
   endtask : send

   task automatic send_byte(input logic [7:0] cmd);
      HB.start;
      send({SLAVE_ADDR, 1'b0}, 1'b1);
      send(cmd, 1'b1);
      HB.stop;
   endtask : send_byte

   task automatic wr2(input logic [7:0] cmd, input logic [7:0] d);
      HB.start;
      send({SLAVE_ADDR, 1'b0}, 1'b1);
      send(cmd, 1'b1);
      send(d, 1'b1);
      HB.stop;
   endtask : wr2

   task automatic rx_one(input logic exp_ack, input logic [15:0] a, input logic ee);
      logic [7:0] d;
      HB.start;
      send({SLAVE_ADDR, 1'b1}, exp_ack);
      if (exp_ack) begin
         HB.rbyte(1'b0, d);
         chk(d, pat(a, ee));
      end
      HB.stop;
      chk(sda_oe, 1'b0);
   endtask : rx_one

   task automatic block_read(input logic [15:0] base, input logic ee);
      logic [7:0] d, crc;
      HB.start;
      send({SLAVE_ADDR, 1'b0}, 1'b1);
      send(CMD_BLOCK_RD, 1'b1);
      HB.start;
      send({SLAVE_ADDR, 1'b1}, 1'b1);
      HB.rbyte(1'b1, d);
      chk(d, BLOCK_COUNT);
      // pec runs over every byte of the transaction, address bytes included
      crc = tb_crc(tb_crc(tb_crc(tb_crc(CRC_INIT, {SLAVE_ADDR, 1'b0}), CMD_BLOCK_RD), {SLAVE_ADDR, 1'b1}), d);
      for (int i = 0; i < 32; i++) begin
         HB.rbyte(1'b1, d);
         chk(d, pat(base + 16'(i), ee));
         crc = tb_crc(crc, d);
      end
      HB.rbyte(1'b0, d);
      chk(d, crc);
      HB.stop;
      chk(sda_oe, 1'b0);
   endtask : block_read

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_foreign_addr;
      HB.start;
      send({SLAVE_ADDR ^ 7'h01, 1'b0}, 1'b0);
      HB.stop;
   endtask : t_foreign_addr

   task automatic t_rx_ram;
      send_byte(8'h25);
      // a ram data write in between must leave the pointer alone
      wr2(8'h10, 8'h5A);
      chk(wr_cap, 16'h105A);
      chk(16'(wr_cnt), 16'h0001);
      rx_one(1'b1, 16'h0025, 1'b0);
   endtask : t_rx_ram

   // pointer load is allowed in any mode, reads are not
   task automatic t_ee_refused;
      wr2(8'h81, 8'hF0);
      rx_one(1'b0, 16'h81F0, 1'b1);
      wr2(EE_MODE_ADDR, 8'h03);
      chk(ee_mode, 8'h03);
      rx_one(1'b0, 16'h81F0, 1'b1);
      HB.start;
      send({SLAVE_ADDR, 1'b0}, 1'b1);
      send(CMD_BLOCK_RD, 1'b0);
      HB.stop;
   endtask : t_ee_refused

   // start near the end of a low-byte page so the pointer carries into the high byte
   task automatic t_block_ee;
      wr2(EE_MODE_ADDR, 8'h01);
      chk(ee_mode, 8'h01);
      wr2(8'h81, 8'hF0);
      rx_one(1'b1, 16'h81F0, 1'b1);
      block_read(16'h81F0, 1'b1);
   endtask : t_block_ee

   task automatic t_block_ram;
      send_byte(8'h50);
      block_read(16'h0050, 1'b0);
   endtask : t_block_ram

   ////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      repeat (12) @(posedge ref_clk);
      #1;
      nrst = 1'b1;
      repeat (4) @(posedge ref_clk);
      #1;
      t_foreign_addr;
      t_rx_ram;
      t_ee_refused;
      t_block_ee;
      t_block_ram;
      tally_and_finish;
   end

   // the whole sequence needs about 20k cycles; twice that can only be a hang
   initial begin
      repeat (40000) @(posedge ref_clk);
      num_errors++;
      $display("ERROR at %0t: watchdog expired, got %h expected %h", $time, 1'b1, 1'b0);
      tally_and_finish;
   end
endmodule : tb_top
`default_nettype wire
